// File: tkt_pkg.sv
package tkt_pkg;

   // command and marker bytes
   localparam logic [7:0] TKT_CMD_COMPAT_WR = 8'ha0;
   localparam logic [7:0] TKT_CMD_AUTH1 = 8'h1a;
   localparam logic [7:0] TKT_AUTH_ARG = 8'h00;
   localparam logic [7:0] TKT_MARK_MORE = 8'haf;
   localparam logic [7:0] TKT_MARK_DONE = 8'h00;
   localparam logic [7:0] TKT_PAGE_MIN = 8'h02;
   localparam logic [7:0] TKT_PAGE_MAX = 8'h2f;

   // four-bit answers
   localparam logic [3:0] TKT_ACK = 4'ha;
   localparam logic [3:0] TKT_NAK_EEPROM = 4'h2;
   localparam logic [3:0] TKT_NAK_CRC = 4'h1;
   localparam logic [3:0] TKT_NAK_OTHER = 4'h0;

   // frame lengths in bytes, crc stripped by the frame layer
   localparam logic [4:0] TKT_LEN_CMD = 5'd2;
   localparam logic [4:0] TKT_LEN_WR_DATA = 5'd16;
   localparam logic [4:0] TKT_LEN_AUTH2 = 5'd17;
   localparam logic [4:0] TKT_LEN_BUF = 5'd17;
   localparam logic [3:0] TKT_LEN_RESP = 4'd9;
   localparam int TKT_BLK_A_POS = 1;
   localparam int TKT_BLK_B_POS = 9;

   // timing
   localparam int TKT_CLK_MHZ = 100;
   localparam int TKT_FC_KHZ = 13560;
   localparam int TKT_FDT_N = 9;
   localparam int TKT_FDT_UNITS = TKT_FDT_N * 128 + 84;
   localparam logic [19:0] TKT_FDT_MIN_CYC =
      20'((TKT_FDT_UNITS * TKT_CLK_MHZ * 1000 + TKT_FC_KHZ - 1) / TKT_FC_KHZ);
   localparam int TKT_TO_P1_MS = 5;
   localparam int TKT_TO_P2_MS = 10;
   localparam logic [19:0] TKT_TO_P1_CYC = 20'(TKT_TO_P1_MS * TKT_CLK_MHZ * 1000);
   localparam logic [19:0] TKT_TO_P2_CYC = 20'(TKT_TO_P2_MS * TKT_CLK_MHZ * 1000);

   typedef enum logic [2:0] {ST_IDLE, ST_CIPH, ST_MEM, ST_WAIT, ST_TX} tkt_state_e;

   typedef struct packed {
      logic valid;
      logic last;
      logic crc_ok;
      logic [7:0] data;
   } tkt_rx_s;

   typedef struct packed {
      logic valid;
      logic nibble;
      logic last;
      logic [7:0] data;
   } tkt_tx_s;

   typedef struct packed {
      logic wr;
      logic [7:0] page;
      logic [31:0] data;
   } tkt_mem_req_s;

   typedef struct packed {
      logic start;
      logic decrypt;
      logic [63:0] blk;
   } tkt_ciph_req_s;

   typedef struct packed {
      tkt_state_e st;
      logic [16:0][7:0] buf_b;
      logic [4:0] cnt_b;
      logic wr_pend;
      logic auth_pend;
      logic authed;
      logic [63:0] card_random_challenge;
      logic [63:0] reader_random_number;
      logic [1:0] step;
      logic busy;
      logic [8:0][7:0] txb;
      logic [3:0] tx_left;
      logic tx_nib;
      logic [19:0] tmr;
      logic [19:0] tmo;
      tkt_mem_req_s mem;
      tkt_ciph_req_s ciph;
   } tkt_core_s;

   localparam tkt_core_s TKT_CORE_RST = '0;

endpackage : tkt_pkg

// File: tkt_wr_auth.sv
`timescale 1ns/1ps
// Functional notes
// - compat write is A0h plus page byte 02h..2Fh, frame closed by CRC
// - of sixteen data bytes only bytes 0..3 go to the page
// - write phase answers not before n=9; reader waits 5 ms, then 10 ms
// - auth frames use same framing, CRC check and ACK/NAK as other commands
// - accepted halt clears the authenticated status
// - valid first pass answers AFh plus eight bytes of encrypted challenge
// - good second pass answers 00h plus encrypted shifted reader random
// - auth answers not before n=9; reader gives up after 5 ms
// - ACK is Ah; NAK codes 2h, 1h, 0h; anything else counts as NAK
// - after any NAK the card resets internally and drops authentication
module tkt_wr_auth #(
   parameter logic [19:0] FDT_MIN_CYC = tkt_pkg::TKT_FDT_MIN_CYC,
   parameter logic [19:0] TO_P1_CYC = tkt_pkg::TKT_TO_P1_CYC,
   parameter logic [19:0] TO_P2_CYC = tkt_pkg::TKT_TO_P2_CYC
) (
   input wire logic clk_sys,              // system clock
   input wire logic rst,                  // synchronous reset
   input tkt_pkg::tkt_rx_s rx,            // received bytes and frame end
   output tkt_pkg::tkt_tx_s tx,           // answer bytes or nibble
   input wire logic tx_ready,             // frame layer takes tx byte
   output tkt_pkg::tkt_mem_req_s mem,     // page write request
   input wire logic mem_done,             // page programming finished
   input wire logic mem_err,              // programming failed
   output tkt_pkg::tkt_ciph_req_s ciph,   // cipher block request
   input wire logic ciph_done,            // cipher result strobe
   input wire logic [63:0] ciph_out,      // cipher result block
   input wire logic [63:0] rnd_in,        // random source
   input wire logic halt_ok,              // halt accepted pulse
   output logic authenticated             // authenticated state
);
   import tkt_pkg::*;

   tkt_core_s s_q;
   tkt_core_s s_d;

   function automatic logic [63:0] tkt_rol8(input logic [63:0] x);
      return {x[55:0], x[63:56]};
   endfunction : tkt_rol8

   function automatic logic [63:0] tkt_blk(input logic [16:0][7:0] b, input int pos);
      logic [63:0] r;
      r = '0;
      for (int i = 0; i < 8; i++) begin
         r[63-8*i -: 8] = b[pos+i];
      end
      return r;
   endfunction : tkt_blk

   function automatic logic [8:0][7:0] tkt_resp(input logic [7:0] mark, input logic [63:0] blk);
      logic [8:0][7:0] r;
      r = '0;
      r[0] = mark;
      for (int i = 0; i < 8; i++) begin
         r[i+1] = blk[63-8*i -: 8];
      end
      return r;
   endfunction : tkt_resp

   // four-bit answer; a NAK also performs the internal reset
   function automatic tkt_core_s tkt_nibble(input tkt_core_s s, input logic [3:0] code);
      tkt_core_s r;
      r = s;
      r.txb = '0;
      r.txb[0] = {4'h0, code};
      r.tx_nib = 1'b1;
      r.tx_left = 4'd1;
      r.st = ST_WAIT;
      r.busy = 1'b0;
      r.mem.wr = 1'b0;
      if (code != TKT_ACK) begin
         r.authed = 1'b0;
         r.wr_pend = 1'b0;
         r.auth_pend = 1'b0;
      end
      return r;
   endfunction : tkt_nibble

   always_comb begin
      s_d = s_q;
      s_d.ciph.start = 1'b0;
      if (s_q.st != ST_IDLE && s_q.tmr != '1) begin
         s_d.tmr = s_q.tmr + 20'd1;
      end
      case (s_q.st)
         ST_IDLE: begin
            if (rx.valid) begin
               if (s_q.cnt_b < TKT_LEN_BUF) begin
                  s_d.buf_b[s_q.cnt_b] = rx.data;
               end
               if (s_q.cnt_b != '1) begin
                  s_d.cnt_b = s_q.cnt_b + 5'd1;
               end
            end
            if (rx.last && s_q.cnt_b != '0) begin
               s_d.cnt_b = '0;
               s_d.tmr = '0;
               if (!rx.crc_ok) begin
                  s_d = tkt_nibble(s_d, TKT_NAK_CRC);
               end else if (s_q.wr_pend) begin
                  s_d.wr_pend = 1'b0;
                  if (s_q.cnt_b == TKT_LEN_WR_DATA) begin
                     // bytes 4..15 are dropped unseen
                     s_d.mem.wr = 1'b1;
                     s_d.mem.data = {s_q.buf_b[3], s_q.buf_b[2], s_q.buf_b[1], s_q.buf_b[0]};
                     s_d.tmo = TO_P2_CYC;
                     s_d.st = ST_MEM;
                  end else begin
                     s_d = tkt_nibble(s_d, TKT_NAK_OTHER);
                  end
               end else if (s_q.buf_b[0] == TKT_CMD_COMPAT_WR) begin
                  s_d.auth_pend = 1'b0;
                  if (s_q.cnt_b == TKT_LEN_CMD && s_q.buf_b[1] >= TKT_PAGE_MIN
                      && s_q.buf_b[1] <= TKT_PAGE_MAX) begin
                     s_d.mem.page = s_q.buf_b[1];
                     s_d.wr_pend = 1'b1;
                     s_d.tmo = TO_P1_CYC;
                     s_d = tkt_nibble(s_d, TKT_ACK);
                  end else begin
                     s_d = tkt_nibble(s_d, TKT_NAK_OTHER);
                  end
               end else if (s_q.buf_b[0] == TKT_CMD_AUTH1) begin
                  s_d.auth_pend = 1'b0;
                  if (s_q.cnt_b == TKT_LEN_CMD && s_q.buf_b[1] == TKT_AUTH_ARG) begin
                     // a new pass one withdraws any earlier authentication
                     s_d.authed = 1'b0;
                     s_d.card_random_challenge = rnd_in;
                     s_d.step = 2'd0;
                     s_d.tmo = TO_P1_CYC;
                     s_d.st = ST_CIPH;
                  end else begin
                     s_d = tkt_nibble(s_d, TKT_NAK_OTHER);
                  end
               end else if (s_q.buf_b[0] == TKT_MARK_MORE) begin
                  s_d.auth_pend = 1'b0;
                  if (s_q.auth_pend && s_q.cnt_b == TKT_LEN_AUTH2) begin
                     s_d.step = 2'd1;
                     s_d.tmo = TO_P1_CYC;
                     s_d.st = ST_CIPH;
                  end else begin
                     s_d = tkt_nibble(s_d, TKT_NAK_OTHER);
                  end
               end else begin
                  // not one of ours: a pending second pass is forgotten
                  s_d.auth_pend = 1'b0;
               end
            end
         end
         ST_CIPH: begin
            if (!s_q.busy) begin
               s_d.busy = 1'b1;
               s_d.ciph.start = 1'b1;
               case (s_q.step)
                  2'd0: begin
                     s_d.ciph.decrypt = 1'b0;
                     s_d.ciph.blk = s_q.card_random_challenge;
                  end
                  2'd1: begin
                     s_d.ciph.decrypt = 1'b1;
                     s_d.ciph.blk = tkt_blk(s_q.buf_b, TKT_BLK_A_POS);
                  end
                  2'd2: begin
                     s_d.ciph.decrypt = 1'b1;
                     s_d.ciph.blk = tkt_blk(s_q.buf_b, TKT_BLK_B_POS);
                  end
                  default: begin
                     s_d.ciph.decrypt = 1'b0;
                     s_d.ciph.blk = tkt_rol8(s_q.reader_random_number);
                  end
               endcase
            end else if (ciph_done) begin
               s_d.busy = 1'b0;
               case (s_q.step)
                  2'd0: begin
                     s_d.txb = tkt_resp(TKT_MARK_MORE, ciph_out);
                     s_d.tx_nib = 1'b0;
                     s_d.tx_left = TKT_LEN_RESP;
                     s_d.auth_pend = 1'b1;
                     s_d.st = ST_WAIT;
                  end
                  2'd1: begin
                     s_d.reader_random_number = ciph_out;
                     s_d.step = 2'd2;
                  end
                  2'd2: begin
                     if (ciph_out == tkt_rol8(s_q.card_random_challenge)) begin
                        s_d.authed = 1'b1;
                        s_d.step = 2'd3;
                     end else begin
                        s_d = tkt_nibble(s_d, TKT_NAK_OTHER);
                     end
                  end
                  default: begin
                     s_d.txb = tkt_resp(TKT_MARK_DONE, ciph_out);
                     s_d.tx_nib = 1'b0;
                     s_d.tx_left = TKT_LEN_RESP;
                     s_d.st = ST_WAIT;
                  end
               endcase
            end
         end
         ST_MEM: begin
            if (mem_done) begin
               s_d = tkt_nibble(s_d, mem_err ? TKT_NAK_EEPROM : TKT_ACK);
            end
         end
         ST_WAIT: begin
            if (s_q.tmr >= FDT_MIN_CYC) begin
               s_d.st = ST_TX;
            end
         end
         default: begin
            if (tx_ready) begin
               s_d.txb = {8'h00, s_q.txb[8:1]};
               s_d.tx_left = s_q.tx_left - 4'd1;
               if (s_q.tx_left == 4'd1) begin
                  s_d.st = ST_IDLE;
               end
            end
         end
      endcase
      // the reader has given up by now; an answer would only collide
      if ((s_q.st == ST_CIPH || s_q.st == ST_MEM) && s_q.tmr >= s_q.tmo) begin
         s_d.st = ST_IDLE;
         s_d.busy = 1'b0;
         s_d.mem.wr = 1'b0;
         s_d.ciph.start = 1'b0;
         s_d.wr_pend = 1'b0;
         s_d.auth_pend = 1'b0;
      end
      if (halt_ok) begin
         s_d.authed = 1'b0;
         s_d.auth_pend = 1'b0;
         s_d.wr_pend = 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         s_q <= TKT_CORE_RST;
      end else begin
         s_q <= s_d;
      end
   end

   assign tx.valid = (s_q.st == ST_TX);
   assign tx.nibble = s_q.tx_nib;
   assign tx.last = (s_q.tx_left == 4'd1);
   assign tx.data = s_q.txb[0];
   assign mem = s_q.mem;
   assign ciph = s_q.ciph;
   assign authenticated = s_q.authed;

   chk_answer_not_early: assert property (
      @(posedge clk_sys) disable iff (rst) tx.valid |-> s_q.tmr >= FDT_MIN_CYC)
      else $error("answer sent before minimum frame delay");
   chk_halt_drops_auth: assert property (
      @(posedge clk_sys) disable iff (rst) halt_ok |=> !authenticated)
      else $error("authentication survived halt");
   chk_nak_drops_auth: assert property (
      @(posedge clk_sys) disable iff (rst)
      tx.valid && tx.nibble && tx.data[3:0] != TKT_ACK |-> !authenticated && !s_q.wr_pend)
      else $error("state kept after NAK");
   chk_wr_page_range: assert property (
      @(posedge clk_sys) disable iff (rst)
      mem.wr |-> mem.page >= TKT_PAGE_MIN && mem.page <= TKT_PAGE_MAX)
      else $error("page write outside legal range");
   chk_wr_after_ack: assert property (
      @(posedge clk_sys) disable iff (rst) $rose(mem.wr) |-> $past(s_q.wr_pend))
      else $error("page write without acknowledged address phase");
   chk_wr_low_bytes: assert property (
      @(posedge clk_sys) disable iff (rst)
      $rose(mem.wr) |-> mem.data[7:0] == $past(s_q.buf_b[0])
      && mem.data[31:24] == $past(s_q.buf_b[3]))
      else $error("page data not taken from bytes 0 to 3");
   chk_crc_nak: assert property (
      @(posedge clk_sys) disable iff (rst)
      s_q.st == ST_IDLE && rx.last && s_q.cnt_b != '0 && !rx.crc_ok
      |=> s_q.st == ST_WAIT && s_q.tx_nib && s_q.txb[0][3:0] == TKT_NAK_CRC)
      else $error("bad CRC not answered with its NAK");
   chk_auth1_reply: assert property (
      @(posedge clk_sys) disable iff (rst)
      s_q.st == ST_CIPH && s_q.busy && s_q.step == 2'd0 && ciph_done && s_q.tmr < s_q.tmo
      |=> s_q.txb[0] == TKT_MARK_MORE && s_q.tx_left == TKT_LEN_RESP && s_q.auth_pend)
      else $error("first pass reply malformed");
   chk_auth_on_match: assert property (
      @(posedge clk_sys) disable iff (rst)
      $rose(authenticated) |-> $past(ciph_done)
      && $past(ciph_out) == tkt_rol8(s_q.card_random_challenge))
      else $error("authenticated without matching challenge");
   chk_auth2_reply: assert property (
      @(posedge clk_sys) disable iff (rst)
      s_q.st == ST_CIPH && s_q.busy && s_q.step == 2'd3 && ciph_done && s_q.tmr < s_q.tmo
      |=> s_q.txb[0] == TKT_MARK_DONE && s_q.tx_left == TKT_LEN_RESP && authenticated)
      else $error("second pass reply malformed");

endmodule : tkt_wr_auth

// File: tkt_far_model.sv
`timescale 1ns/1ps
module tkt_far_model
   import tkt_pkg::*;
#(
   parameter logic [63:0] KEY = 64'h5a3c_96e1_0f7b_24d8
) (
   input wire logic clk_sys,              // system clock
   input wire logic rst,                  // synchronous reset
   input tkt_mem_req_s mem,               // page write request
   output logic mem_done = 1'b0,          // programming finished pulse
   output logic mem_err = 1'b0,           // programming failed, with mem_done
   input tkt_ciph_req_s ciph,             // cipher block request
   output logic ciph_done = 1'b0,         // cipher result pulse
   output logic [63:0] ciph_out = '0,     // cipher result block
   input wire logic [9:0] lat,            // answer latency in cycles, at least 1
   input wire logic fail_wr               // make programming fail
);
   logic [31:0] pages [48];
   logic [9:0] mcnt = '0;
   logic [9:0] ccnt = '0;
   logic mbusy = 1'b0;
   logic cbusy = 1'b0;
   logic [63:0] cres = '0;

   // adding the key stands in for the block cipher and decrypt subtracts it,
   // so a request made in the wrong direction shows up as a wrong answer
   always @(posedge clk_sys) begin
      mem_done <= 1'b0;
      ciph_done <= 1'b0;
      mem_err <= ~fail_wr;
      ciph_out <= ~cres;
      if (rst) begin
         mbusy <= 1'b0;
         cbusy <= 1'b0;
      end else begin
         if (!mem.wr) begin
            mbusy <= 1'b0;
         end else if (!mbusy) begin
            mbusy <= 1'b1;
            mcnt <= lat;
         end else if (mcnt != 0) begin
            mcnt <= mcnt - 10'd1;
            if (mcnt == 10'd1) begin
               mem_done <= 1'b1;
               mem_err <= fail_wr;
               if (!fail_wr) begin
                  pages[mem.page] <= mem.data;
               end
            end
         end
         if (ciph.start) begin
            cbusy <= 1'b1;
            ccnt <= lat;
            cres <= ciph.decrypt ? ciph.blk - KEY : ciph.blk + KEY;
         end else if (cbusy) begin
            ccnt <= ccnt - 10'd1;
            if (ccnt == 10'd1) begin
               ciph_done <= 1'b1;
               ciph_out <= cres;
               cbusy <= 1'b0;
            end
         end
      end
   end
endmodule : tkt_far_model

// File: ticket_write_auth_commands_test.sv
`timescale 1ns/1ps
module ticket_write_auth_commands_test;
   import tkt_pkg::*;
   localparam logic [19:0] FDT = 20'd20;
   localparam logic [63:0] KEY = 64'h5a3c_96e1_0f7b_24d8;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic tx_ready = 1'b0;
   logic halt_ok = 1'b0;
   logic fail_wr = 1'b0;
   logic [9:0] lat = 10'd3;
   logic [63:0] rnd_in = '0;
   tkt_rx_s rx = '0;
   tkt_tx_s tx;
   tkt_mem_req_s mem;
   tkt_ciph_req_s ciph;
   logic mem_done, mem_err, ciph_done, authenticated;
   logic [63:0] ciph_out;
   int mismatches = 0;
   int tests_run = 0;
   logic [7:0] q [$];
   logic [7:0] e [$];

   always #5 clk_sys = ~clk_sys;

   tkt_wr_auth #(.FDT_MIN_CYC(FDT), .TO_P1_CYC(20'd200), .TO_P2_CYC(20'd400)) dut (
      .clk_sys(clk_sys), .rst(rst), .rx(rx), .tx(tx), .tx_ready(tx_ready), .mem(mem),
      .mem_done(mem_done), .mem_err(mem_err), .ciph(ciph), .ciph_done(ciph_done),
      .ciph_out(ciph_out), .rnd_in(rnd_in), .halt_ok(halt_ok), .authenticated(authenticated));

   tkt_far_model #(.KEY(KEY)) far (
      .clk_sys(clk_sys), .rst(rst), .mem(mem), .mem_done(mem_done), .mem_err(mem_err),
      .ciph(ciph), .ciph_done(ciph_done), .ciph_out(ciph_out), .lat(lat), .fail_wr(fail_wr));

   task automatic print_verdict;
      if (mismatches == 0 && tests_run > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : print_verdict

   task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   function automatic logic [63:0] rol8(input logic [63:0] v);
      return {v[55:0], v[63:56]};
   endfunction : rol8

   task automatic push(ref logic [7:0] d [$], input logic [63:0] v);
      for (int k = 7; k >= 0; k--) d.push_back(v[8*k +: 8]); // first byte in the top lane
   endtask : push

   // the crc itself is stripped below us; only its verdict reaches the block
   task automatic send(input bit crc);
      foreach (q[i]) begin
         @(negedge clk_sys);
         rx <= '{valid: 1'b1, last: 1'b0, crc_ok: 1'b0, data: q[i]};
      end
      @(negedge clk_sys);
      rx <= '{valid: 1'b0, last: 1'b1, crc_ok: crc, data: 8'h00};
      @(negedge clk_sys);
      rx <= '0;
   endtask : send

   // an empty e means the card must stay silent for the whole limit
   task automatic recv(input bit nib, input int limit);
      int n;
      int i;
      bit go;
      n = 0;
      i = 0;
      while (tx.valid !== 1'b1 && n < limit) begin
         @(negedge clk_sys);
         n++;
      end
      if (e.size() == 0) begin
         check("silence", 64'h0, tx.valid);
         return;
      end
      check("answer not early", 64'h1, n > FDT);
      while (i < e.size() && n < limit + 64) begin
         go = $urandom_range(2) != 0;
         if (go) begin
            check("answer valid", 64'h1, tx.valid);
            check("nibble flag", nib, tx.nibble);
            check("answer byte", e[i], nib ? {4'h0, tx.data[3:0]} : tx.data);
            check("last flag", i == e.size() - 1, tx.last);
            i++;
         end
         tx_ready <= go;
         @(negedge clk_sys);
         n++;
      end
      tx_ready <= 1'b0;
      check("answer ended", 64'h0, tx.valid);
   endtask : recv

   task automatic do_write(input logic [7:0] pg, input bit err);
      q = {TKT_CMD_COMPAT_WR, pg};
      send(1'b1);
      if (pg < TKT_PAGE_MIN || pg > TKT_PAGE_MAX) begin
         e = {8'h00};
         recv(1'b1, 100);
         return;
      end
      e = {8'h0a};
      recv(1'b1, 100);
      q = {};
      for (int k = 0; k < 16; k++) q.push_back(k < 4 ? 8'($urandom) : 8'h00);
      fail_wr <= err;
      send(1'b1);
      e = {err ? 8'h02 : 8'h0a};
      recv(1'b1, 600);
      fail_wr <= 1'b0;
      if (!err) check("page content", {q[3], q[2], q[1], q[0]}, far.pages[pg]);
   endtask : do_write

   task automatic do_auth(input bit good);
      logic [63:0] r;
      logic [63:0] a;
      r = {$urandom, $urandom};
      a = {$urandom, $urandom};
      rnd_in <= r;
      q = {TKT_CMD_AUTH1, TKT_AUTH_ARG};
      send(1'b1);
      e = {TKT_MARK_MORE};
      push(e, r + KEY);
      recv(1'b0, 200);
      q = {TKT_MARK_MORE};
      push(q, a + KEY);
      push(q, (good ? rol8(r) : r) + KEY);
      send(1'b1);
      e = {good ? TKT_MARK_DONE : 8'h00};
      if (good) push(e, rol8(a) + KEY);
      recv(!good, 200);
      check("auth state", good, authenticated);
   endtask : do_auth

   initial begin
      #500000;
      mismatches++;
      print_verdict();
   end

   initial begin
      logic [7:0] corner [4];
      corner = '{8'h01, 8'h02, 8'h2f, 8'h30};
      void'($urandom(2));
      repeat (3) @(posedge clk_sys);
      @(negedge clk_sys);
      rst <= 1'b0;
      @(negedge clk_sys);
      check("auth after reset", 64'h0, authenticated);
      foreach (corner[i]) do_write(corner[i], 1'b0);
      repeat (3) do_write(8'($urandom_range(47, 2)), 1'b0);
      do_auth(1'b1);
      halt_ok <= 1'b1;
      @(negedge clk_sys);
      halt_ok <= 1'b0;
      @(negedge clk_sys);
      check("auth after halt", 64'h0, authenticated);
      do_auth(1'b0);
      do_auth(1'b1);
      do_write(8'h10, 1'b1);
      check("auth after nak", 64'h0, authenticated);
      q = {TKT_CMD_AUTH1, TKT_AUTH_ARG};
      send(1'b0);
      e = {8'h01};
      recv(1'b1, 100);
      q = {TKT_CMD_AUTH1, 8'h01};
      send(1'b1);
      e = {8'h00};
      recv(1'b1, 100);
      lat <= 10'd300;
      q = {TKT_CMD_AUTH1, TKT_AUTH_ARG};
      send(1'b1);
      e = {};
      recv(1'b0, 400);
      lat <= 10'd3;
      q = {TKT_MARK_MORE};
      push(q, 64'h0);
      push(q, 64'h0);
      send(1'b1);
      e = {8'h00};
      recv(1'b1, 100);
      lat <= 10'd350;
      do_write(8'h05, 1'b0);
      lat <= 10'd3;
      print_verdict();
   end
endmodule : ticket_write_auth_commands_test
